/* File: spmc_defs.svh */
// constants for the serial port configuration block
// assumes a 50 MHz pclk and a 32-bit apb master
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH
`define SPMC_CLK_HZ       50000000
`define SPMC_SEC_MS       1000
// register offsets, port 2 adds SPMC_PORT_STRIDE
`define SPMC_OFS_CFG      3'h0
`define SPMC_OFS_ADDR     3'h1
`define SPMC_OFS_RATE     3'h2
`define SPMC_OFS_IDLE     3'h3
`define SPMC_OFS_DLINE    3'h4
`define SPMC_OFS_TXDATA   3'h5
`define SPMC_OFS_STATUS   3'h6
`define SPMC_PORT_STRIDE  32'h0000_0020
`define SPMC_OFS_INDEX    32'h0000_0040
// protocol codes
`define SPMC_PROTO_OFF    2'h0
`define SPMC_PROTO_VENDOR 2'h1
`define SPMC_PROTO_ASCII  2'h2
`define SPMC_PROTO_RTU    2'h3
// parity codes
`define SPMC_PAR_NONE     2'h0
`define SPMC_PAR_ODD      2'h1
`define SPMC_PAR_EVEN     2'h2
// line rates in units of 100 baud
`define SPMC_RATE_4K8     16'h0030
`define SPMC_RATE_9K6     16'h0060
`define SPMC_RATE_19K2    16'h00c0
`define SPMC_RATE_115K2   16'h0480
// slave address limits
`define SPMC_ADDR_MIN     16'h0001
`define SPMC_ADDR_MAX     16'h00f7
// reset values
`define SPMC_CFG_RST      16'h0083
`define SPMC_ADDR_RST     16'h0001
`define SPMC_IDLE_RST     16'h0000
`define SPMC_DLINE_RST    16'h1388
`define SPMC_INDEX_RST    1'h0
// holding register map
`define SPMC_HR_PRI_INDEX 16'habdf
`define SPMC_HR_SEC_INDEX 16'habde
`define SPMC_HR_FMT_BASE  16'hb3b0
`define SPMC_HR_VAL_BASE  16'habe0
`endif

/* File: spmc_pkg.sv */
// types for the serial port configuration block
// assumes spmc_defs.svh supplies the numbers
package spmc_pkg;
  // per-port configuration word
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       modem;
    logic [1:0] rsv_lo;
    logic [1:0] stop;
    logic [3:0] chlen;
    logic [1:0] parity;
    logic [1:0] proto;
  } spmc_cfg_s;
  // per-port status word
  typedef struct packed {
    logic resp_ok;
    logic hung;
    logic addr_ok;
    logic busy;
  } spmc_stat_s;
  typedef enum logic {SPMC_TX_IDLE, SPMC_TX_SHIFT} spmc_tx_e;
endpackage

/* File: spmc_serial_port_cfg.sv */
// two-port serial configuration, transmit framing and modem idle hang-up
// assumes an apb master on pclk; rx pins are asynchronous
//
// Contract
// - protocol 0 off, 1 vendor, 2 modbus ascii, 3 modbus rtu; preset 3.
// - modbus slave address must be 1 to 247 and unique on network.
// - slave address is ignored under the vendor protocol.
// - rates 4800, 9600, 19200, 115200; presets 115200 port 1, 19200 port 2.
// - any rate value accepted; only the four listed rates guaranteed.
// - parity 0 none, 1 odd, 2 even; preset none.
// - 5 to 8 data bits; rtu uses 8, ascii and vendor 7 or 8; the code takes 5 to 8 under every protocol.
// - one or two stop bits as configured; preset one.
// - modem setting 0 none, 1 answer only; preset 0.
// - idle line until timer expiry commands modem hang-up.
// - inactivity timeout applies only with answer-only modem.
// - modbus master drivers disregard inactivity timeout.
// - index placement 0: global primary and secondary index registers.
// - index placement 1: per-parameter format words paired with values.
// - index placement ignored unless protocol is modbus.
// - settings kept separately for rs-232 port 1 and rs-485 port 2; index placement is one bit shared by both ports.
// - response suppressed once request age exceeds deadline; preset 5000 ms.
//
// Added by the designer: the APB register port and the register addresses.
`include "spmc_defs.svh"

module spmc_serial_port_cfg
  import spmc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SPMC_CLK_HZ,
  parameter int unsigned MS_CYCLES  = `SPMC_CLK_HZ / `SPMC_SEC_MS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial lines, index 0 is rs-232, index 1 is rs-485
  input  wire logic [1:0]  rx_i,
  output logic      [1:0]  tx_o,
  // modem and parameter access control
  output logic      [1:0]  hangup_o,
  output logic      [1:0]  port_en_o,
  output logic      [1:0]  index_from_format_o
);

  // ==========================================================
  // apb decode
  logic        acc;
  logic        wr;
  logic        hit_idx;
  logic [1:0]  hit_port;
  logic [2:0]  sel_reg;
  logic        index_sel_q;
  logic [31:0] port_rd [2];

  assign acc      = psel && penable;
  assign wr       = acc && pwrite && !pslverr;
  assign sel_reg  = paddr[4:2];
  assign hit_idx  = paddr == `SPMC_OFS_INDEX;
  assign pready   = 1'b1;
  always_comb begin
    hit_port = 2'h0;
    if (paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0 &&
        sel_reg <= `SPMC_OFS_STATUS) begin
      hit_port[paddr[5]] = 1'b1;
    end
  end
  assign pslverr = acc && !hit_idx && hit_port == 2'h0;

  always_comb begin
    prdata = 32'h0;
    if (hit_idx) begin
      prdata = {31'h0, index_sel_q};
    end else if (hit_port[0]) begin
      prdata = port_rd[0];
    end else if (hit_port[1]) begin
      prdata = port_rd[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_sel_q <= `SPMC_INDEX_RST;
    end else if (wr && hit_idx) begin
      index_sel_q <= pwdata[0];
    end
  end

  // ==========================================================
  // second and millisecond ticks
  logic [31:0] sec_cnt_q;
  logic [31:0] ms_cnt_q;
  logic        sec_tick;
  logic        ms_tick;

  assign sec_tick = sec_cnt_q == SEC_CYCLES - 1;
  assign ms_tick  = ms_cnt_q == MS_CYCLES - 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q <= 32'h0;
    end else begin
      sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= 32'h0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // character frame, bit 0 goes out first
  function automatic logic [11:0] frame_f(logic [7:0] d, logic [3:0] n,
                                          logic [1:0] par);
    logic [11:0] f;
    logic [7:0]  dm;
    f  = 12'hfff;
    dm = d & 8'((9'h1 << n) - 9'h1);
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) f[i+1] = dm[i];
    end
    if (par == `SPMC_PAR_ODD) f[n+1] = ~^dm;
    if (par == `SPMC_PAR_EVEN) f[n+1] = ^dm;
    return f;
  endfunction

  // ==========================================================
  // per-port logic
  for (genvar p = 0; p < 2; p++) begin : g_port
    spmc_cfg_s   cfg_q;
    spmc_stat_s  stat;
    spmc_tx_e    tx_state_q;
    logic [15:0] addr_q, rate_q, idle_q, dline_q;
    logic [15:0] idle_cnt_q, dl_cnt_q;
    logic [13:0] div, baud_cnt_q;
    logic [11:0] shift_q;
    logic [3:0]  bits_q, n_eff, n_bits;
    logic        rx_s1_q, rx_s2_q, rx_s3_q, rx_fall;
    logic        modbus, tx_start, wr_tx, armed_q, hung_q, resp_ok_q;
    logic        hang;

    assign modbus = cfg_q.proto == `SPMC_PROTO_ASCII ||
                    cfg_q.proto == `SPMC_PROTO_RTU;
    assign port_en_o[p] = cfg_q.proto != `SPMC_PROTO_OFF;
    assign index_from_format_o[p] = modbus && index_sel_q;

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q   <= `SPMC_CFG_RST;
        addr_q  <= `SPMC_ADDR_RST;
        rate_q  <= p == 0 ? `SPMC_RATE_115K2 : `SPMC_RATE_19K2;
        idle_q  <= `SPMC_IDLE_RST;
        dline_q <= `SPMC_DLINE_RST;
      end else if (wr && hit_port[p]) begin
        unique case (sel_reg)
          `SPMC_OFS_CFG:   cfg_q   <= pwdata[15:0];
          `SPMC_OFS_ADDR:  addr_q  <= pwdata[15:0];
          `SPMC_OFS_RATE:  rate_q  <= pwdata[15:0];
          `SPMC_OFS_IDLE:  idle_q  <= pwdata[15:0];
          `SPMC_OFS_DLINE: dline_q <= pwdata[15:0];
          default: ;
        endcase
      end
    end

    // address check, vendor protocol ignores the address
    assign stat.addr_ok = cfg_q.proto == `SPMC_PROTO_VENDOR ||
      (modbus && addr_q >= `SPMC_ADDR_MIN &&
       addr_q <= `SPMC_ADDR_MAX);
    assign stat.busy    = tx_state_q == SPMC_TX_SHIFT;
    assign stat.hung    = hung_q;
    assign stat.resp_ok = resp_ok_q;

    always_comb begin
      port_rd[p] = 32'h0;
      unique case (sel_reg)
        `SPMC_OFS_CFG:    port_rd[p] = {16'h0, cfg_q};
        `SPMC_OFS_ADDR:   port_rd[p] = {16'h0, addr_q};
        `SPMC_OFS_RATE:   port_rd[p] = {16'h0, rate_q};
        `SPMC_OFS_IDLE:   port_rd[p] = {16'h0, idle_q};
        `SPMC_OFS_DLINE:  port_rd[p] = {16'h0, dline_q};
        `SPMC_OFS_STATUS: port_rd[p] = {28'h0, stat};
        default: ;
      endcase
    end

    // unlisted rates fall back to 19200
    always_comb begin
      unique case (rate_q)
        `SPMC_RATE_4K8:   div = 14'(`SPMC_CLK_HZ / 4800);
        `SPMC_RATE_9K6:   div = 14'(`SPMC_CLK_HZ / 9600);
        `SPMC_RATE_115K2: div = 14'(`SPMC_CLK_HZ / 115200);
        default:          div = 14'(`SPMC_CLK_HZ / 19200);
      endcase
    end

    // rx synchroniser and falling-edge detect (any high-to-low rx transition)
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_s1_q <= 1'b1;
        rx_s2_q <= 1'b1;
        rx_s3_q <= 1'b1;
      end else begin
        rx_s1_q <= rx_i[p];
        rx_s2_q <= rx_s1_q;
        rx_s3_q <= rx_s2_q;
      end
    end
    assign rx_fall = rx_s3_q && !rx_s2_q;

    // response deadline from last incoming falling edge on rx
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dl_cnt_q  <= 16'h0;
        resp_ok_q <= 1'b0;
      end else if (rx_fall) begin
        dl_cnt_q  <= 16'h0;
        resp_ok_q <= 1'b1;
      end else if (ms_tick && resp_ok_q) begin
        dl_cnt_q  <= dl_cnt_q + 16'h1;
        if (dl_cnt_q >= dline_q) resp_ok_q <= 1'b0;
      end
    end

    // transmitter
    assign wr_tx    = wr && hit_port[p] && sel_reg == `SPMC_OFS_TXDATA;
    assign tx_start = wr_tx && tx_state_q == SPMC_TX_IDLE &&
                      port_en_o[p] && resp_ok_q;
    assign n_eff = cfg_q.chlen < 4'h5 ? 4'h5 :
                   cfg_q.chlen > 4'h8 ? 4'h8 : cfg_q.chlen;
    assign n_bits = 4'h1 + n_eff + 4'(cfg_q.parity != `SPMC_PAR_NONE) +
                    (cfg_q.stop == 2'h2 ? 4'h2 : 4'h1);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_state_q <= SPMC_TX_IDLE;
        shift_q    <= 12'hfff;
        bits_q     <= 4'h0;
        baud_cnt_q <= 14'h0;
      end else begin
        unique case (tx_state_q)
          SPMC_TX_IDLE: if (tx_start) begin
            shift_q    <= frame_f(pwdata[7:0], n_eff, cfg_q.parity);
            bits_q     <= n_bits;
            baud_cnt_q <= 14'h0;
            tx_state_q <= SPMC_TX_SHIFT;
          end
          SPMC_TX_SHIFT: if (baud_cnt_q == div - 14'h1) begin
            baud_cnt_q <= 14'h0;
            shift_q    <= {1'b1, shift_q[11:1]};
            bits_q     <= bits_q - 4'h1;
            if (bits_q == 4'h1) tx_state_q <= SPMC_TX_IDLE;
          end else begin
            baud_cnt_q <= baud_cnt_q + 14'h1;
          end
        endcase
      end
    end
    assign tx_o[p] = tx_state_q == SPMC_TX_IDLE || shift_q[0];

    // modem inactivity hang-up, only for an answer-only modem
    assign hang = armed_q && cfg_q.modem && idle_q != 16'h0 && !rx_fall &&
                  !tx_start && sec_tick &&
                  idle_cnt_q + 16'h1 >= idle_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        idle_cnt_q <= 16'h0;
        armed_q    <= 1'b1;
        hung_q     <= 1'b0;
      end else if (rx_fall || tx_start) begin
        idle_cnt_q <= 16'h0;
        armed_q    <= 1'b1;
        hung_q     <= 1'b0;
      end else if (!cfg_q.modem || idle_q == 16'h0) begin
        idle_cnt_q <= 16'h0;
      end else if (hang) begin
        armed_q    <= 1'b0;
        hung_q     <= 1'b1;
      end else if (sec_tick && armed_q) begin
        idle_cnt_q <= idle_cnt_q + 16'h1;
      end
    end
    assign hangup_o[p] = hang;

    // ========================================================
    // checks
    AST_OFF_QUIET: assert property (@(posedge pclk)
      disable iff (!presetn) cfg_q.proto == `SPMC_PROTO_OFF &&
      tx_state_q == SPMC_TX_IDLE |=> tx_state_q == SPMC_TX_IDLE)
      else $error("disabled port started a character");
    AST_ZERO_ADDR: assert property (@(posedge pclk)
      disable iff (!presetn) modbus && addr_q == 16'h0 |-> !stat.addr_ok)
      else $error("broadcast address accepted");
    AST_VENDOR_ADDR: assert property (@(posedge pclk)
      disable iff (!presetn)
      cfg_q.proto == `SPMC_PROTO_VENDOR |-> stat.addr_ok)
      else $error("vendor protocol checked the address");
    AST_START_BIT: assert property (@(posedge pclk)
      disable iff (!presetn) tx_start |=> !tx_o[p] [*2])
      else $error("start bit missing");
    AST_STOP_HIGH: assert property (@(posedge pclk)
      disable iff (!presetn) tx_state_q == SPMC_TX_SHIFT &&
      bits_q == 4'h1 |-> tx_o[p])
      else $error("stop bit low");
    AST_BAUD_DIV: assert property (@(posedge pclk)
      disable iff (!presetn) tx_state_q == SPMC_TX_SHIFT |-> baud_cnt_q < div)
      else $error("bit period overrun");
    AST_HANG_MODEM: assert property (@(posedge pclk)
      disable iff (!presetn)
      hangup_o[p] |-> cfg_q.modem && idle_q != 16'h0 ##1 !hangup_o[p])
      else $error("hang-up without answer-only modem");
    AST_LATE_RESP: assert property (@(posedge pclk)
      disable iff (!presetn) wr_tx && !resp_ok_q &&
      tx_state_q == SPMC_TX_IDLE |=> tx_state_q == SPMC_TX_IDLE && tx_o[p])
      else $error("late response transmitted");
    AST_INDEX_MB: assert property (@(posedge pclk)
      disable iff (!presetn) !modbus |-> !index_from_format_o[p])
      else $error("index placement used without modbus");
  end

endmodule

/* File: spmc_line_partner.sv */
// far-side serial line model: sends request characters, frames tx output
// assumes the line settings given match those of the port it faces
module spmc_line_partner (
  // clock
  input  wire logic        clk,
  // line settings
  input  wire logic [15:0] div,
  input  wire logic [3:0]  nbits,
  input  wire logic [1:0]  par,
  input  wire logic [1:0]  nstop,
  // lines and results
  input  wire logic        kick,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             got,
  output logic [8:0]       word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] s;
  logic [7:0] b;
  logic       e;
  initial begin
    line_out = 1'b1;
    got = 1'b0;
    word = 9'h000;
  end
  // ==========
  // request character toward the block
  always @(posedge kick) begin
    s = 8'h3a;
    line_out <= 1'b0;
    repeat (div) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= s[i];
      repeat (div) @(posedge clk);
    end
    if (par != 2'h0) begin
      line_out <= ^(s & ~(8'hff << nbits)) ^ (par == 2'h1);
      repeat (div) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (div * nstop) @(posedge clk);
  end
  // ==========
  // mid-bit sampling of each transmitted character
  always begin
    @(negedge line_in);
    repeat (div / 2) @(posedge clk);
    e = line_in;
    b = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (div) @(posedge clk);
      b[i] = line_in;
    end
    if (par != 2'h0) begin
      repeat (div) @(posedge clk);
      e = e | (line_in !== (^b ^ (par == 2'h1)));
    end
    for (int i = 0; i < nstop; i++) begin
      repeat (div) @(posedge clk);
      e = e | (line_in !== 1'b1);
    end
    word <= {e, b};
    got <= 1'b1;
    @(posedge clk);
    got <= 1'b0;
  end
endmodule

/* File: spmc_tb.sv */
// self-checking bench for the serial port configuration block
// assumes the line model on port 0; port 1 line held idle
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SEC = 20;
  localparam int unsigned MS  = 10;
  localparam logic [31:0] RA [11] = '{32'h00, 32'h04, 32'h08, 32'h0c,
    32'h10, 32'h14, 32'h18, 32'h1c, 32'h20, 32'h28, 32'h40};
  localparam logic [32:0] RV [11] = '{33'h83, 33'h1, 33'h480, 33'h0,
    33'h1388, 33'h0, 33'h2, 33'h1_0000_0000, 33'h83, 33'hc0, 33'h0};
  localparam logic [15:0] AV [4] = '{16'h0, 16'h1, 16'hf7, 16'hf8};
  localparam logic [31:0] FC [3] = '{32'h28a, 32'h077, 32'h053};
  localparam logic [31:0] FR [3] = '{32'h480, 32'h480, 32'h123};
  localparam int FD [3] = '{434, 434, 2604};
  localparam int FN [3] = '{8, 7, 5};
  localparam int FP [3] = '{2, 1, 0};
  localparam int FS [3] = '{2, 1, 1};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rnd, rd;
  logic [1:0]  tx_o, hangup_o, port_en_o, idx_o, rx_i, p_par, p_ns;
  logic        kick, far_rx, far_got;
  logic [15:0] p_div;
  logic [3:0]  p_nb;
  logic [8:0]  far_word;
  logic [33:0] mq;
  logic [33:0] exp_q[$];
  logic [8:0]  frm_q[$];
  int          mismatches, check_count, hangs, n0;
  assign rx_i = {1'b1, far_rx};
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  spmc_serial_port_cfg #(.SEC_CYCLES(SEC), .MS_CYCLES(MS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_i(rx_i), .tx_o(tx_o),
    .hangup_o(hangup_o), .port_en_o(port_en_o),
    .index_from_format_o(idx_o));
  spmc_line_partner far (
    .clk(pclk), .div(p_div), .nbits(p_nb), .par(p_par), .nstop(p_ns),
    .kick(kick), .line_in(tx_o[0]), .line_out(far_rx), .got(far_got),
    .word(far_word));
  // ==========
  // shared tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdx(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic poll(input logic [31:0] a);
    exp_q.push_back({1'b1, 33'h0});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // output watcher: reads, frames, hang-up pulses
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      mq = exp_q.pop_front();
      if (!mq[33]) chk("read", mq, {1'b0, pslverr, prdata});
    end
    if (far_got === 1'b1) begin
      if (frm_q.size() == 0) chk("frame", 34'h0, 34'h1);
      else chk("frame", 34'(frm_q.pop_front()), 34'(far_word));
    end
    if (hangup_o[0] === 1'b1) hangs++;
    if (hangup_o[1] === 1'b1) hangs += 100;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    conclude();
  end
  // ==========
  // main sequence
  initial begin
    {psel, penable, pwrite, kick, presetn} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rnd = 32'hc560;
    {p_div, p_nb, p_par, p_ns} = {16'd434, 4'd8, 2'h0, 2'h1};
    repeat (16) @(posedge pclk);
    chk("lines", 34'({idx_o, port_en_o, tx_o}), 34'h0f);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) rdx(RA[i], RV[i]);
    for (int i = 0; i < 4; i++) begin
      wr(32'h24, {16'hffff, AV[i]});
      rdx(32'h24, {17'h0, AV[i]});
      rdx(32'h38, 33'({AV[i] != 0 && AV[i] < 16'hf8, 1'b0}));
    end
    for (int k = 0; k < 8; k++) begin
      wr(32'h40, 32'(k / 4));
      wr(32'h20, 32'h80 | 32'(k % 4));
      @(negedge pclk);
      chk("ctl", 34'({idx_o, port_en_o}), 34'({k >= 6, k >= 4, k % 4 != 0,
          1'b1}));
    end
    for (int c = 0; c < 3; c++) begin
      wr(32'h08, FR[c]);
      wr(32'h00, FC[c]);
      p_div = 16'(FD[c]);
      {p_nb, p_par, p_ns} = {4'(FN[c]), 2'(FP[c]), 2'(FS[c])};
      kick <= 1'b1;
      repeat (8) @(posedge pclk);
      kick <= 1'b0;
      rdx(32'h18, 33'ha);
      for (int j = 0; j < 2; j++) begin
        rnd = xs(rnd);
        frm_q.push_back({1'b0, rnd[7:0] & ~(8'hff << FN[c])});
        wr(32'h14, rnd);
        do poll(32'h18); while (rd[0] !== 1'b0);
      end
    end
    wr(32'h08, 32'h480);
    wr(32'h00, 32'h83);
    wr(32'h10, 32'h2);
    {p_div, p_nb, p_par, p_ns} = {16'd434, 4'd8, 2'h0, 2'h1};
    kick <= 1'b1;
    repeat (5000) @(posedge pclk);
    kick <= 1'b0;
    wr(32'h14, 32'h55);
    rdx(32'h18, 33'h2);
    wr(32'h34, 32'h55);
    rdx(32'h38, 33'h0);
    chk("port 2 line", 34'h1, 34'(tx_o[1]));
    for (int h = 0; h < 3; h++) begin
      wr(32'h00, 32'h83);
      wr(32'h0c, h == 1 ? 32'h0 : 32'h2);
      kick <= 1'b1;
      repeat (8) @(posedge pclk);
      n0 = hangs;
      wr(32'h00, h == 2 ? 32'h83 : 32'h1083);
      repeat (150) @(posedge pclk);
      kick <= 1'b0;
      chk("hangups", 34'(h == 0), 34'(hangs - n0));
      rdx(32'h18, h == 0 ? 33'h6 : 33'h2);
      repeat (4400) @(posedge pclk);
    end
    chk("frames left", 34'h0, 34'(frm_q.size()));
    conclude();
  end
endmodule
